/* File: verilog/tap_pkg.sv */
// constants and types shared by the boundary-scan test port
package tap_pkg;

	// ----------------------------------------------------------------
	// register widths and synchroniser depth
	// ----------------------------------------------------------------
	localparam int IR_W        = 4;
	localparam int ID_W        = 32;
	localparam int SYNC_STAGES = 3;

	// ----------------------------------------------------------------
	// pin population; 16 + 17 + 3 * 4 = 45 chain cells
	// ----------------------------------------------------------------
	localparam int N_IN     = 16;
	localparam int N_OUT    = 17;
	localparam int N_BI     = 4;
	localparam int BI_CELLS = 3;
	localparam int BI_IN    = 0;
	localparam int BI_DATA  = 1;
	localparam int BI_CTL   = 2;

	// ----------------------------------------------------------------
	// instruction codes
	// ----------------------------------------------------------------
	localparam logic [IR_W-1:0] IR_EXTEST  = 4'h0;
	localparam logic [IR_W-1:0] IR_SAMPLE  = 4'h1;
	localparam logic [IR_W-1:0] IR_CLAMP   = 4'h2;
	localparam logic [IR_W-1:0] IR_HIGHZ   = 4'h3;
	localparam logic [IR_W-1:0] IR_IDCODE  = 4'h6;
	localparam logic [IR_W-1:0] IR_BYPASS  = 4'hf;
	localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

	// ----------------------------------------------------------------
	// identification word layout; field values are arbitrary
	// ----------------------------------------------------------------
	localparam int          ID_VER_LSB  = 28;
	localparam int          ID_PART_LSB = 12;
	localparam int          ID_MFR_LSB  = 1;
	localparam logic [3:0]  ID_VERSION  = 4'h2;
	localparam logic [15:0] ID_PART     = 16'h1234;
	localparam logic [10:0] ID_MFR      = 11'h055;
	localparam logic        ID_ONE      = 1'b1;

	// ----------------------------------------------------------------
	// controller states and data register selection
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		TEST_RESET, RUN_IDLE,
		SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
		SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
	} tap_state_type;

	typedef enum logic [1:0] {
		PATH_BSR, PATH_ID, PATH_BYPASS
	} dr_path_type;

endpackage : tap_pkg

/* File: verilog/pin_sync.sv */
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ns
module pin_sync #(
	parameter int              WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '1
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             resetn_in,
	// asynchronous inputs
	input  wire logic [WIDTH-1:0] async_in,
	// filtered level and edge pulses
	output logic      [WIDTH-1:0] level_out,
	output logic      [WIDTH-1:0] rise_out,
	output logic      [WIDTH-1:0] fall_out
);

	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// ----------------------------------------------------------------
	// per bit: a change counts only once stages two and three agree
	// ----------------------------------------------------------------
	genvar i;
	for (i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk_in) begin
			if (!resetn_in) begin
				s1[i]        <= INIT[i];
				s2[i]        <= INIT[i];
				s3[i]        <= INIT[i];
				level_out[i] <= INIT[i];
				rise_out[i]  <= 1'b0;
				fall_out[i]  <= 1'b0;
			end else begin
				s1[i]        <= async_in[i];
				s2[i]        <= s1[i];
				s3[i]        <= s2[i];
				if (s2[i] == s3[i]) begin
					level_out[i] <= s3[i];
				end
				rise_out[i] <= (s2[i] == s3[i]) && s3[i] && !level_out[i];
				fall_out[i] <= (s2[i] == s3[i]) && !s3[i] && level_out[i];
			end
		end
	end

endmodule : pin_sync

/* File: verilog/boundary_scan_tap.sv */
// boundary-scan test access port with 45-cell chain
`timescale 1ns/1ns

// Contract
// RL1 - tms, tck, tdi, tdo plus async test reset
// RL2 - after test reset, id register sits in path
// RL3 - update loads shifted code, else idcode
// RL4 - unassigned codes behave as bypass
// RL5 - code 0000 drives pins from chain cells
// RL6 - tester preloads cells before external test
// RL7 - sample/preload snapshots pins, system undisturbed
// RL8 - id word fields, shifted lsb first
// RL9 - clamp holds pins, bypass in path
// RL10 - highz floats outputs, bypass in path
// RL11 - bypass is one stage, one tck delay
// RL12 - every pin has cells; bidir has three
// RL13 - sixteen-state controller, tdo on falling tck
// RL14 - fixed documented cell order in chain
module boundary_scan_tap #(
	parameter int N_IN  = tap_pkg::N_IN,
	parameter int N_OUT = tap_pkg::N_OUT,
	parameter int N_BI  = tap_pkg::N_BI
) (
	// clock and reset
	input  wire logic             mclk_in,
	input  wire logic             resetn_in,
	// test port
	input  wire logic             tck_in,
	input  wire logic             tms_in,
	input  wire logic             tdi_in,
	input  wire logic             tap_async_reset_n_in,
	output logic                  tdo_out,
	output logic                  tdo_oe_n_out,
	// input pins and core side
	input  wire logic [N_IN-1:0]  board_in,
	output logic      [N_IN-1:0]  core_in_out,
	// output pins and core side
	input  wire logic [N_OUT-1:0] core_out_in,
	output logic      [N_OUT-1:0] board_out_out,
	output logic      [N_OUT-1:0] board_out_oe_n_out,
	// bidirectional pins and core side
	input  wire logic [N_BI-1:0]  bi_core_out_in,
	input  wire logic [N_BI-1:0]  bi_core_oe_n_in,
	output logic      [N_BI-1:0]  bi_core_in_out,
	input  wire logic [N_BI-1:0]  bi_board_in,
	output logic      [N_BI-1:0]  bi_board_out,
	output logic      [N_BI-1:0]  bi_board_oe_n_out
);

	// ----------------------------------------------------------------
	// chain layout
	// ----------------------------------------------------------------
	localparam int OUT_BASE = N_IN;
	localparam int BI_BASE  = N_IN + N_OUT;
	localparam int BSR_W    = BI_BASE + tap_pkg::BI_CELLS * N_BI;

	tap_pkg::tap_state_type     state;
	tap_pkg::tap_state_type     next_state;
	tap_pkg::dr_path_type       path;
	logic [3:0]                 lvl;
	logic [3:0]                 rise;
	logic [3:0]                 fall;
	logic                       tck_rise;
	logic                       tck_fall;
	logic                       tms;
	logic                       tdi;
	logic                       test_reset;
	logic [tap_pkg::IR_W-1:0]   ir;
	logic [tap_pkg::IR_W-1:0]   ir_shift;
	logic                       ir_new;
	logic [tap_pkg::ID_W-1:0]   id_shift;
	logic [tap_pkg::ID_W-1:0]   id_value;
	logic                       bypass;
	logic [BSR_W-1:0]           bsr_shift;
	logic [BSR_W-1:0]           bsr_upd;
	logic [BSR_W-1:0]           bsr_cap;
	logic                       drive_bsr;
	logic                       float_all;
	logic [N_OUT-1:0]           next_out;
	logic [N_BI-1:0]            next_bi;
	logic [N_BI-1:0]            next_bi_oe_n;
	logic                       next_tdo;

	// ----------------------------------------------------------------
	// test port sampling; tck is seen only through its edges
	// ----------------------------------------------------------------
	pin_sync #(
		.WIDTH (4),
		.INIT  (4'hf)
	) u_sync (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.async_in  ({tap_async_reset_n_in, tdi_in, tms_in, tck_in}),
		.level_out (lvl),
		.rise_out  (rise),
		.fall_out  (fall)
	);

	// tms and tdi share the tck latency, so their levels line up
	assign tck_rise   = rise[0];
	assign tck_fall   = fall[0];
	assign tms        = lvl[1];
	assign tdi        = lvl[2];
	// acts on level alone, no tck edge needed
	assign test_reset = !lvl[3]; // RL1

	// ----------------------------------------------------------------
	// controller
	// ----------------------------------------------------------------
	always_comb begin
		unique case (state) // RL13
			tap_pkg::TEST_RESET: next_state = tms ? tap_pkg::TEST_RESET
			                                      : tap_pkg::RUN_IDLE;
			tap_pkg::RUN_IDLE:   next_state = tms ? tap_pkg::SEL_DR
			                                      : tap_pkg::RUN_IDLE;
			tap_pkg::SEL_DR:     next_state = tms ? tap_pkg::SEL_IR
			                                      : tap_pkg::CAP_DR;
			tap_pkg::CAP_DR:     next_state = tms ? tap_pkg::EXIT1_DR
			                                      : tap_pkg::SHIFT_DR;
			tap_pkg::SHIFT_DR:   next_state = tms ? tap_pkg::EXIT1_DR
			                                      : tap_pkg::SHIFT_DR;
			tap_pkg::EXIT1_DR:   next_state = tms ? tap_pkg::UPD_DR
			                                      : tap_pkg::PAUSE_DR;
			tap_pkg::PAUSE_DR:   next_state = tms ? tap_pkg::EXIT2_DR
			                                      : tap_pkg::PAUSE_DR;
			tap_pkg::EXIT2_DR:   next_state = tms ? tap_pkg::UPD_DR
			                                      : tap_pkg::SHIFT_DR;
			tap_pkg::UPD_DR:     next_state = tms ? tap_pkg::SEL_DR
			                                      : tap_pkg::RUN_IDLE;
			tap_pkg::SEL_IR:     next_state = tms ? tap_pkg::TEST_RESET
			                                      : tap_pkg::CAP_IR;
			tap_pkg::CAP_IR:     next_state = tms ? tap_pkg::EXIT1_IR
			                                      : tap_pkg::SHIFT_IR;
			tap_pkg::SHIFT_IR:   next_state = tms ? tap_pkg::EXIT1_IR
			                                      : tap_pkg::SHIFT_IR;
			tap_pkg::EXIT1_IR:   next_state = tms ? tap_pkg::UPD_IR
			                                      : tap_pkg::PAUSE_IR;
			tap_pkg::PAUSE_IR:   next_state = tms ? tap_pkg::EXIT2_IR
			                                      : tap_pkg::PAUSE_IR;
			tap_pkg::EXIT2_IR:   next_state = tms ? tap_pkg::UPD_IR
			                                      : tap_pkg::SHIFT_IR;
			tap_pkg::UPD_IR:     next_state = tms ? tap_pkg::SEL_DR
			                                      : tap_pkg::RUN_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in || test_reset) begin
			state <= tap_pkg::TEST_RESET; // RL1
		end else if (tck_rise) begin
			state <= next_state; // RL13
		end
	end

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in || test_reset || state == tap_pkg::TEST_RESET) begin
			ir       <= tap_pkg::IR_IDCODE; // RL2
			ir_shift <= tap_pkg::IR_CAPTURE;
			ir_new   <= 1'b0;
		end else if (tck_rise && state == tap_pkg::CAP_IR) begin
			ir_shift <= tap_pkg::IR_CAPTURE;
			ir_new   <= 1'b0;
		end else if (tck_rise && state == tap_pkg::SHIFT_IR) begin
			ir_shift <= {tdi, ir_shift[tap_pkg::IR_W-1:1]};
			ir_new   <= 1'b1;
		end else if (tck_fall && state == tap_pkg::UPD_IR) begin
			// decoded outputs only move here or in test-logic reset, never while shifting
			ir     <= ir_new ? ir_shift : tap_pkg::IR_IDCODE; // RL3
			ir_new <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// instruction decode
	// ----------------------------------------------------------------
	always_comb begin
		drive_bsr = 1'b0;
		float_all = 1'b0;
		unique case (ir)
			tap_pkg::IR_EXTEST: begin
				path      = tap_pkg::PATH_BSR; // RL5
				drive_bsr = 1'b1; // RL5
			end
			tap_pkg::IR_SAMPLE: begin
				path = tap_pkg::PATH_BSR; // RL7
			end
			tap_pkg::IR_IDCODE: begin
				path = tap_pkg::PATH_ID;
			end
			tap_pkg::IR_CLAMP: begin
				path      = tap_pkg::PATH_BYPASS; // RL9
				drive_bsr = 1'b1; // RL9
			end
			tap_pkg::IR_HIGHZ: begin
				path      = tap_pkg::PATH_BYPASS; // RL10
				float_all = 1'b1; // RL10
			end
			default: begin
				path = tap_pkg::PATH_BYPASS; // RL4 RL11
			end
		endcase
	end

	// ----------------------------------------------------------------
	// identification word
	// ----------------------------------------------------------------
	always_comb begin
		id_value = '0;
		id_value[tap_pkg::ID_VER_LSB +: 4]   = tap_pkg::ID_VERSION; // RL8
		id_value[tap_pkg::ID_PART_LSB +: 16] = tap_pkg::ID_PART; // RL8
		id_value[tap_pkg::ID_MFR_LSB +: 11]  = tap_pkg::ID_MFR; // RL8
		id_value[0]                          = tap_pkg::ID_ONE; // RL8
	end

	// ----------------------------------------------------------------
	// chain cells: inputs, then outputs, then in/data/ctl per bidir
	// ----------------------------------------------------------------
	genvar i;
	for (i = 0; i < N_IN; i++) begin : g_in
		assign bsr_cap[i] = board_in[i]; // RL12 RL14
	end
	for (i = 0; i < N_OUT; i++) begin : g_out
		assign bsr_cap[OUT_BASE+i] = board_out_out[i]; // RL12 RL14
		assign next_out[i] = drive_bsr ? bsr_upd[OUT_BASE+i]
		                               : core_out_in[i]; // RL5 RL9
	end
	for (i = 0; i < N_BI; i++) begin : g_bi
		localparam int B = BI_BASE + tap_pkg::BI_CELLS * i;
		assign bsr_cap[B+tap_pkg::BI_IN]   = bi_board_in[i]; // RL12 RL14
		assign bsr_cap[B+tap_pkg::BI_DATA] = bi_board_out[i]; // RL12
		assign bsr_cap[B+tap_pkg::BI_CTL]  = bi_board_oe_n_out[i]; // RL12
		assign next_bi[i] = drive_bsr ? bsr_upd[B+tap_pkg::BI_DATA]
		                              : bi_core_out_in[i];
		assign next_bi_oe_n[i] = float_all ? 1'b1 :
		                         drive_bsr ? bsr_upd[B+tap_pkg::BI_CTL]
		                                   : bi_core_oe_n_in[i]; // RL10
	end

	// ----------------------------------------------------------------
	// data registers
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			id_shift  <= '0;
			bypass    <= 1'b0;
			bsr_shift <= '0;
		end else if (tck_rise && state == tap_pkg::CAP_DR) begin
			unique case (path)
				tap_pkg::PATH_BSR:    bsr_shift <= bsr_cap; // RL7
				tap_pkg::PATH_ID:     id_shift  <= id_value; // RL2
				tap_pkg::PATH_BYPASS: bypass    <= 1'b0;
			endcase
		end else if (tck_rise && state == tap_pkg::SHIFT_DR) begin
			unique case (path)
				tap_pkg::PATH_BSR:
					bsr_shift <= {tdi, bsr_shift[BSR_W-1:1]};
				tap_pkg::PATH_ID:
					id_shift <= {tdi, id_shift[tap_pkg::ID_W-1:1]}; // RL8
				tap_pkg::PATH_BYPASS:
					bypass <= tdi; // RL11
			endcase
		end
	end

	// update cells hold through clamp, since only the chain path loads them
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			bsr_upd <= '0;
		end else if (tck_fall && state == tap_pkg::UPD_DR &&
		             path == tap_pkg::PATH_BSR) begin
			bsr_upd <= bsr_shift; // RL7 RL9
		end
	end

	// ----------------------------------------------------------------
	// serial output, moved on falling tck
	// ----------------------------------------------------------------
	always_comb begin
		unique case (path)
			tap_pkg::PATH_BSR:    next_tdo = bsr_shift[0];
			tap_pkg::PATH_ID:     next_tdo = id_shift[0];
			tap_pkg::PATH_BYPASS: next_tdo = bypass;
		endcase
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in || test_reset) begin
			tdo_out      <= 1'b0;
			tdo_oe_n_out <= 1'b1;
		end else if (tck_fall) begin
			tdo_oe_n_out <= !(state == tap_pkg::SHIFT_IR ||
			                  state == tap_pkg::SHIFT_DR); // RL13
			// tdo holds outside shifting, so a released line never wiggles
			if (state == tap_pkg::SHIFT_IR) begin
				tdo_out <= ir_shift[0]; // RL13
			end else if (state == tap_pkg::SHIFT_DR) begin
				tdo_out <= next_tdo; // RL13
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drivers; one mclk of latency keeps every output on a flop
	// ----------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			core_in_out        <= '0;
			bi_core_in_out     <= '0;
			board_out_out      <= '0;
			board_out_oe_n_out <= '1;
			bi_board_out       <= '0;
			bi_board_oe_n_out  <= '1;
		end else begin
			// core keeps seeing live pins, so sampling is non-intrusive
			core_in_out        <= board_in; // RL7
			bi_core_in_out     <= bi_board_in;
			board_out_out      <= next_out;
			board_out_oe_n_out <= {N_OUT{float_all}}; // RL10
			bi_board_out       <= next_bi;
			bi_board_oe_n_out  <= next_bi_oe_n;
		end
	end

endmodule : boundary_scan_tap

/* File: testbench/boundary_scan_tap_props.sv */
// assertions on the pins of the boundary-scan test port
`timescale 1ns/1ns
module boundary_scan_tap_props #(
	parameter int N_OUT = tap_pkg::N_OUT
) (
	// watched pins
	input wire logic             mclk_in,
	input wire logic             resetn_in,
	input wire logic             tck_in,
	input wire logic             tap_async_reset_n_in,
	input wire logic             tdo_out,
	input wire logic             tdo_oe_n_out,
	input wire logic [N_OUT-1:0] board_out_oe_n_out
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (!resetn_in);
	// ------------------------------------------------------------
	// assertions; tck is synchronised, so edges show ~4 mclk late
	// ------------------------------------------------------------
	a_tdo_on_fall: assert property (
		$changed(tdo_out) && tap_async_reset_n_in |-> !$past(tck_in, 3))
		else $error("tdo moved away from a falling tck");
	a_oe_on_fall: assert property (
		$changed(tdo_oe_n_out) && tap_async_reset_n_in
		|-> !$past(tck_in, 3))
		else $error("tdo enable moved away from a falling tck");
	a_oe_min_bit: assert property (
		$fell(tdo_oe_n_out) |-> !tdo_oe_n_out [*7])
		else $error("tdo enable shorter than one tck period");
	a_outs_uniform: assert property (
		board_out_oe_n_out == '0 || board_out_oe_n_out == '1)
		else $error("output enables not all equal");
	a_pins_frozen: assert property (
		(tap_async_reset_n_in && $stable(tck_in)) [*8]
		|-> $stable(board_out_oe_n_out))
		else $error("output enables moved with tck idle");
	a_tdo_frozen: assert property (
		(tap_async_reset_n_in && $stable(tck_in)) [*8]
		|-> $stable(tdo_out))
		else $error("tdo moved with tck idle");
	a_tdo_hold_off: assert property (
		tdo_oe_n_out && $past(tdo_oe_n_out) && tap_async_reset_n_in
		|-> $stable(tdo_out))
		else $error("tdo moved while not driven");
	a_async_reset: assert property (
		!tap_async_reset_n_in [*6] |-> tdo_oe_n_out)
		else $error("tdo driven during test reset");
	c_shift: cover property ($fell(tdo_oe_n_out));
	c_float: cover property (board_out_oe_n_out == '1);
	c_async: cover property ($fell(tap_async_reset_n_in));
endmodule : boundary_scan_tap_props
bind boundary_scan_tap boundary_scan_tap_props #(.N_OUT(N_OUT)) boundary_scan_tap_props_inst (
	.mclk_in(mclk_in), .resetn_in(resetn_in), .tck_in(tck_in),
	.tap_async_reset_n_in(tap_async_reset_n_in), .tdo_out(tdo_out),
	.tdo_oe_n_out(tdo_oe_n_out), .board_out_oe_n_out(board_out_oe_n_out));

/* File: testbench/scan_tester.sv */
// scan tester model that walks the test controller from outside
`timescale 1ns/1ns
module scan_tester (
	// clock
	input  wire logic mclk_in,
	// test port
	output logic      tck_out,
	output logic      tms_out,
	output logic      tdi_out,
	input  wire logic tdo_in,
	input  wire logic tdo_oe_n_in
);
	logic tdo_seen;
	logic oe_seen;
	logic oe_ok;
	initial begin
		tck_out = 1'b1;
		tms_out = 1'b1;
		tdi_out = 1'b0;
		oe_ok   = 1'b1;
	end
	// one 320 ns tck period from a falling mclk; tdo is read just before
	// the next fall since the port answers ~200 ns after tck falls
	task automatic step(input logic m, input logic d);
		tck_out = 1'b0;
		tms_out = m;
		tdi_out = d;
		repeat (4) @(negedge mclk_in);
		tck_out = 1'b1;
		repeat (4) @(negedge mclk_in);
		tdo_seen = tdo_in;
		oe_seen  = tdo_oe_n_in;
	endtask : step
	// outside shifts tdi toggles so stale data never looks valid
	task automatic idle(input logic m);
		step(m, ~tdi_out);
	endtask : idle
	task automatic tap_reset();
		@(negedge mclk_in);
		repeat (5) idle(1'b1);
		idle(1'b0);
	endtask : tap_reset
	// from run-idle: shift n bits lsb first, update, back to run-idle
	task automatic scan(input logic ir, input int n,
		input logic [63:0] din, output logic [63:0] dout);
		int i;
		@(negedge mclk_in);
		dout  = '0;
		oe_ok = 1'b1;
		idle(1'b1);
		if (ir) idle(1'b1);
		idle(1'b0);
		idle(1'b0);
		for (i = 0; i < n; i++) begin
			step(i == n - 1, din[i]);
			dout[i] = tdo_seen;
			oe_ok &= (oe_seen === 1'b0);
		end
		idle(1'b1);
		oe_ok &= (oe_seen === 1'b1);
		idle(1'b0);
	endtask : scan
endmodule : scan_tester

/* File: testbench/boundary_scan_tap_test.sv */
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ns
module boundary_scan_tap_test;
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        async_n = 1'b1;
	logic        tck, tms, tdi, tdo, tdo_oe_n;
	logic [15:0] board_pins;
	logic [15:0] core_in;
	logic [16:0] core_out = 17'h1a5c3;
	logic [16:0] out_pins, out_oe_n;
	logic [3:0]  bi_core_out;
	logic [3:0]  bi_core_oe_n;
	logic [3:0]  bi_ext = 4'h9;
	logic [3:0]  bi_core_in, bi_pins, bi_drv, bi_oe_n, pd, pc;
	logic [63:0] got;
	logic [44:0] pre = 45'h1_6a5c_3c96_e1f;
	int          err_total = 0;
	int          num_checks = 0;
	localparam logic [31:0] ID_EXP = {tap_pkg::ID_VERSION,
		tap_pkg::ID_PART, tap_pkg::ID_MFR, tap_pkg::ID_ONE};
	always #20 mclk = ~mclk;
	// bidir pin level: the port drives when enabled, else the board does
	assign bi_pins = (~bi_oe_n & bi_drv) | (bi_oe_n & bi_ext);
	boundary_scan_tap boundary_scan_tap_inst (
		.mclk_in(mclk), .resetn_in(resetn), .tck_in(tck), .tms_in(tms),
		.tdi_in(tdi), .tap_async_reset_n_in(async_n), .tdo_out(tdo),
		.tdo_oe_n_out(tdo_oe_n), .board_in(board_pins),
		.core_in_out(core_in), .core_out_in(core_out),
		.board_out_out(out_pins), .board_out_oe_n_out(out_oe_n),
		.bi_core_out_in(bi_core_out), .bi_core_oe_n_in(bi_core_oe_n),
		.bi_core_in_out(bi_core_in), .bi_board_in(bi_pins),
		.bi_board_out(bi_drv), .bi_board_oe_n_out(bi_oe_n));
	scan_tester scan_tester_inst (
		.mclk_in(mclk), .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
		.tdo_in(tdo), .tdo_oe_n_in(tdo_oe_n));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [44:0] exp_chain(input logic [16:0] o,
		input logic [3:0] d, input logic [3:0] c);
		logic [44:0] v;
		int          k;
		v[15:0]  = board_pins;
		v[32:16] = o;
		for (k = 0; k < 4; k++) begin
			v[33+3*k] = c[k] ? bi_ext[k] : d[k];
			v[34+3*k] = d[k];
			v[35+3*k] = c[k];
		end
		return v;
	endfunction : exp_chain
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic load_ir(input logic [3:0] code);
		scan_tester_inst.scan(1'b1, 4, {60'h0, code}, got);
		check(got[3:0], tap_pkg::IR_CAPTURE);
	endtask : load_ir
	task automatic dr(input int n, input logic [63:0] din);
		scan_tester_inst.scan(1'b0, n, din, got);
		check(scan_tester_inst.oe_ok, 1'b1);
	endtask : dr
	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : conclude
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_idcode();
		scan_tester_inst.tap_reset();
		dr(32, 64'h0);
		check(got[31:0], ID_EXP);
		$display("idcode done");
	endtask : t_idcode
	task automatic t_bypass();
		logic [3:0] codes [13] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8,
			4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf};
		foreach (codes[i]) begin
			load_ir(codes[i]);
			dr(8, 64'hb2);
			check(got[7:0], 8'h64);
		end
		$display("bypass codes done");
	endtask : t_bypass
	task automatic t_sample();
		load_ir(tap_pkg::IR_SAMPLE);
		dr(45, {19'h0, pre});
		check(got[44:0], exp_chain(core_out, bi_core_out, bi_core_oe_n));
		check(out_pins, core_out);
		check(bi_drv, bi_core_out);
		check(core_in, board_pins);
		check(bi_core_in, bi_pins);
		$display("sample done");
	endtask : t_sample
	task automatic t_extest();
		// cells were preloaded by the sample scan just before
		load_ir(tap_pkg::IR_EXTEST);
		for (int k = 0; k < 4; k++) begin
			pd[k] = pre[34+3*k];
			pc[k] = pre[35+3*k];
		end
		check(out_pins, pre[32:16]);
		check(bi_drv, pd);
		check(bi_oe_n, pc);
		// live pins move and core data changes; capture must show the new pins, the driven cells must ignore the core
		board_pins  = 16'h3ca5;
		bi_core_out = 4'h9;
		dr(45, {19'h0, pre});
		check(got[44:0], exp_chain(pre[32:16], pd, pc));
		check(bi_drv, pd);
		check(core_in, board_pins);
		$display("extest done");
	endtask : t_extest
	task automatic t_clamp_highz();
		load_ir(tap_pkg::IR_CLAMP);
		core_out = ~core_out;
		dr(8, 64'hb2);
		check(out_pins, pre[32:16]);
		load_ir(tap_pkg::IR_HIGHZ);
		check(out_oe_n, 17'h1ffff);
		check(bi_oe_n, 4'hf);
		$display("clamp and highz done");
	endtask : t_clamp_highz
	task automatic t_ir_default();
		scan_tester_inst.idle(1'b1);
		scan_tester_inst.idle(1'b1);
		scan_tester_inst.idle(1'b0);
		scan_tester_inst.idle(1'b1);
		scan_tester_inst.idle(1'b1);
		scan_tester_inst.idle(1'b0);
		check(out_oe_n, 17'h0);
		dr(32, 64'h0);
		check(got[31:0], ID_EXP);
		$display("ir default done");
	endtask : t_ir_default
	task automatic t_async();
		load_ir(tap_pkg::IR_HIGHZ);
		async_n = 1'b0;
		repeat (8) @(negedge mclk);
		check(tdo_oe_n, 1'b1);
		check(out_oe_n, 17'h0);
		async_n = 1'b1;
		repeat (8) @(negedge mclk);
		scan_tester_inst.idle(1'b0);
		dr(32, 64'h0);
		check(got[31:0], ID_EXP);
		$display("async reset done");
	endtask : t_async
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		board_pins   = 16'hc35a;
		bi_core_out  = 4'h6;
		bi_core_oe_n = 4'h3;
		repeat (6) @(negedge mclk);
		resetn = 1'b1;
		repeat (8) @(negedge mclk);
		t_idcode();
		t_bypass();
		t_sample();
		t_extest();
		t_clamp_highz();
		t_ir_default();
		t_async();
		conclude();
	end
	initial begin
		repeat (100000) @(posedge mclk);
		err_total++;
		$display("ERROR at %0t: run did not finish", $time);
		conclude();
	end
endmodule : boundary_scan_tap_test
